//--- design/bps_supervisor.sv
// Protection and mode supervisor of a synchronous step-down converter
// Function
// - Mode pin high forces PWM, low power-save
// - Valid external clock aligns cycles, forces PWM
// - Forced PWM is pin OR force bit
// - Spreading varies period about ten percent, triangular
// - Spreading needs enable bit and no external clock
// - Spreading also runs in power-save operation
// - Discharge needs enable bit, reset enabled
// - Discharge on disable, thermal, low or high supply
// - No discharge before first enable after power-up
// - Low supply stops switching, discharges if allowed
// - High supply stops switching, restarts with soft start
// - High-side trip forces low side until current drops
// - Retry bit picks hiccup or plain limiting
// - 32 limited cycles pause switching, then restart
// - Hiccup sets flag, holds power-ok low until restart
// - Status read clears hiccup only without overload
// - Four limited cycles set current limit flag
// - Status read clears limit flag only without overload
// - Primary drives power-ok open-drain, secondary reads it
// - Window fault pulls power-ok low
// - Power-ok rising edge deglitched by 40us
// - Blank bit hides window fault during ramps
// - Power-ok low in thermal, disabled, lockout, soft start
`timescale 1ns/1ps
`default_nettype none
`include "bps_params.svh"
module bps_supervisor
    import bps_pkg::*;
#(
    parameter int PERIOD_CYC = 50,
    parameter int EXT_MIN_CYC = 20,
    parameter int EXT_MAX_CYC = 100,
    parameter int HICCUP_CYC = `BPS_HICCUP_PAUSE_NS / `BPS_CLK_NS,
    parameter int DEGLITCH_CYC = `BPS_POK_DEGLITCH_NS / `BPS_CLK_NS
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic en_pin,
    input wire logic mode_clk_pin,
    input wire bps_faults_t faults,
    input wire logic hs_limit_trip,
    input wire logic ls_below_limit,
    input wire logic window_fault,
    input wire logic voltage_ramping,
    input wire logic soft_start_done,
    input wire logic secondary_strap,
    input wire logic power_ok_pin_i,
    output logic power_ok_pin_o,
    output logic power_ok_pin_oe,
    output logic switching_run,
    output logic hs_on_allow,
    output logic ls_force_on,
    output logic cycle_tick,
    output logic continuous_switching,
    output logic power_save_operation,
    output logic signed [7:0] spread_offset,
    output logic discharge_on,
    output logic soft_start_req,
    output logic dcm_only
);
    // Spreading amplitude in cycles
    localparam int AMP_I = PERIOD_CYC * `BPS_SPREAD_PCT / 100;
    localparam logic signed [7:0] AMP = 8'(AMP_I);
    localparam logic [5:0] HIC_N = 6'(`BPS_HICCUP_CYCLES);
    localparam logic [5:0] LIMIT_N = 6'(`BPS_LIMIT_CYCLES);

    // Register index match, shared by read and write decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] k);
        hit = (a == k);
    endfunction : hit

    bps_core_t r_reg, r_next;
    // Synchronised copies of asynchronous inputs
    logic [7:0] sy;
    logic tsd, lo_sup, hi_sup, mode_s, trip_s, below_s, wfault_s, pok_in_s;
    // Derived conditions
    logic go, mode_rise, osc_wrap, spread_on, overload, hic_hit, raw_pok;
    logic pause_done, pok_done, pok_on, st_read;
    logic signed [10:0] period_len;
    logic [5:0] consec_inc;

    // Fault, mode, current, window and power-ok levels pass two flops first; en_pin is used directly
    bps_sync #(.W(8)) u_sync (
        .clock(clock),
        .rstn(rstn),
        .d({faults, mode_clk_pin, hs_limit_trip, ls_below_limit,
            window_fault, power_ok_pin_i}),
        .q(sy)
    );
    assign {tsd, lo_sup, hi_sup, mode_s, trip_s, below_s, wfault_s,
        pok_in_s} = sy;

    // Hiccup pause: runs only while the converter is paused
    bps_timer u_pause (
        .clock(clock),
        .rstn(rstn),
        .run(r_reg.st == BPS_PAUSE),
        .limit(16'(HICCUP_CYC)),
        .done(pause_done)
    );
    // Power-ok deglitch on the rising side only
    bps_timer u_deglitch (
        .clock(clock),
        .rstn(rstn),
        .run(raw_pok),
        .limit(16'(DEGLITCH_CYC)),
        .done(pok_done)
    );

    // Combinational conditions feeding the state update
    always_comb begin
        // Lockouts and disable stop the converter
        go = en_pin && r_reg.ctrl.switching_enable_bit && !tsd && !lo_sup
            && !hi_sup;
        mode_rise = mode_s && !r_reg.mode_d;
        period_len = 11'(PERIOD_CYC) + 11'(r_reg.tri_ofs);
        osc_wrap = ({1'b0, r_reg.osc} >= period_len - 11'sd1);
        // External clock edges replace the oscillator
        cycle_tick = r_reg.ext_lock ? mode_rise : osc_wrap;
        // Works in either mode, never beside an external clock
        spread_on = r_reg.ctrl.spread_enable_bit && !r_reg.ext_lock;
        consec_inc = (r_reg.consec == 6'h3f) ? r_reg.consec
            : r_reg.consec + 6'h01;
        overload = r_reg.limiting || r_reg.cyc_limited
            || (r_reg.consec != 6'h00) || (r_reg.st == BPS_PAUSE);
        hic_hit = cycle_tick && r_reg.cyc_limited && (r_reg.st == BPS_RUN)
            && r_reg.ctrl.retry_mode_enable_bit
            && (consec_inc >= HIC_N);
        // Window fault ignored during a ramp when blanking is set
        raw_pok = (r_reg.st == BPS_RUN) && go && !r_reg.secondary
            && (!wfault_s || (r_reg.blank && voltage_ramping));
        pok_on = raw_pok && pok_done;
        st_read = reg_rd && hit(reg_addr, `BPS_ADDR_STATUS);
    end

    // Next state of the whole core
    always_comb begin
        r_next = r_reg;
        r_next.mode_d = mode_s;
        r_next.pok_in_d = pok_in_s;
        r_next.ss_req = 1'b0;
        // Role strap caught once after reset release
        if (!r_reg.strap_done) begin
            r_next.secondary = secondary_strap;
            r_next.strap_done = 1'b1;
        end
        if (en_pin) begin
            r_next.enabled_once = 1'b1;
        end

        // Register writes
        if (reg_wr && hit(reg_addr, `BPS_ADDR_CTRL1)) begin
            r_next.ctrl = reg_wdata[4:0];
        end
        if (reg_wr && hit(reg_addr, `BPS_ADDR_CTRL3)) begin
            r_next.blank = reg_wdata[`BPS_C3_BLANK];
        end

        // Read data, valid the cycle after the strobe
        r_next.rdata = 8'h00;
        if (reg_rd) begin
            case (1'b1)
                hit(reg_addr, `BPS_ADDR_CTRL1): r_next.rdata = {3'h0,
                    r_reg.ctrl};
                hit(reg_addr, `BPS_ADDR_CTRL3): r_next.rdata = {7'h00,
                    r_reg.blank};
                st_read: r_next.rdata = {2'h0, pok_on, r_reg.ext_lock,
                    r_reg.secondary, tsd, r_reg.current_limit_flag,
                    r_reg.hiccup_flag};
                default: r_next.rdata = 8'h00;
            endcase
        end

        // External clock qualification by edge spacing
        r_next.gap = (r_reg.gap == 10'h3ff) ? r_reg.gap
            : r_reg.gap + 10'h001;
        if (mode_rise) begin
            r_next.gap = 10'h000;
            r_next.ext_lock = (r_reg.gap >= 10'(EXT_MIN_CYC))
                && (r_reg.gap <= 10'(EXT_MAX_CYC));
        end else if (r_reg.gap > 10'(EXT_MAX_CYC)) begin
            r_next.ext_lock = 1'b0;
        end

        // Internal oscillator, restarted on each switching cycle
        r_next.osc = (cycle_tick || osc_wrap) ? 10'h000
            : r_reg.osc + 10'h001;

        // Triangular period offset, one step per cycle
        if (!spread_on) begin
            r_next.tri_ofs = 8'sh00;
            r_next.tri_up = 1'b1;
        end else if (cycle_tick) begin
            if (r_reg.tri_up) begin
                r_next.tri_ofs = r_reg.tri_ofs + 8'sh01;
                r_next.tri_up = (r_reg.tri_ofs + 8'sh01 < AMP);
            end else begin
                r_next.tri_ofs = r_reg.tri_ofs - 8'sh01;
                r_next.tri_up = (r_reg.tri_ofs - 8'sh01 <= -AMP);
            end
        end

        // Cycle limit: low side on until current falls back
        if (trip_s) begin
            r_next.limiting = 1'b1;
        end else if (below_s) begin
            r_next.limiting = 1'b0;
        end

        // Count consecutive limited cycles at each cycle boundary
        if (cycle_tick) begin
            r_next.consec = r_reg.cyc_limited ? consec_inc : 6'h00;
            r_next.cyc_limited = trip_s;
        end else if (trip_s) begin
            r_next.cyc_limited = 1'b1;
        end

        // Read clears flags only once the overload is gone
        if (st_read && !overload) begin
            r_next.hiccup_flag = 1'b0;
            r_next.current_limit_flag = 1'b0;
        end
        // Flag-only mode: four limited cycles in a row
        if (cycle_tick && r_reg.cyc_limited && (r_reg.st == BPS_RUN)
            && !r_reg.ctrl.retry_mode_enable_bit
            && (consec_inc >= LIMIT_N)) begin
            r_next.current_limit_flag = 1'b1;
        end
        if (hic_hit) begin
            r_next.hiccup_flag = 1'b1;
        end

        // Secondary: leave DCM on the shared power-ok rising edge
        if (r_reg.st != BPS_RUN) begin
            r_next.ccm_ok = 1'b0;
        end else if (pok_in_s && !r_reg.pok_in_d) begin
            r_next.ccm_ok = 1'b1;
        end

        // Sequencing
        case (r_reg.st)
            BPS_OFF: begin
                if (go) begin
                    r_next.st = BPS_SOFTSTART;
                    r_next.ss_req = 1'b1;
                end
            end
            BPS_SOFTSTART: begin
                if (!go) begin
                    r_next.st = BPS_OFF;
                end else if (soft_start_done) begin
                    r_next.st = BPS_RUN;
                end
            end
            BPS_RUN: begin
                if (!go) begin
                    r_next.st = BPS_OFF;
                end else if (hic_hit) begin
                    r_next.st = BPS_PAUSE;
                end
            end
            BPS_PAUSE: begin
                if (!go) begin
                    r_next.st = BPS_OFF;
                end else if (pause_done) begin
                    r_next.st = BPS_SOFTSTART;
                    r_next.ss_req = 1'b1;
                end
            end
            default: r_next.st = BPS_OFF;
        endcase
        // Counts start afresh whenever switching stops
        if (r_next.st != BPS_RUN) begin
            r_next.consec = 6'h00;
            r_next.cyc_limited = 1'b0;
        end
    end

    // Core register; control bits come up at their reset values
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '0;
            r_reg.st <= BPS_OFF;
            r_reg.ctrl <= `BPS_CTRL1_RST;
            r_reg.blank <= `BPS_CTRL3_RST;
            r_reg.tri_up <= 1'b1;
            r_reg.gap <= 10'h3ff;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs
    always_comb begin
        switching_run = (r_reg.st == BPS_SOFTSTART) || (r_reg.st == BPS_RUN);
        hs_on_allow = switching_run && !r_reg.limiting;
        ls_force_on = switching_run && r_reg.limiting;
        continuous_switching = mode_s || r_reg.ctrl.force_pwm_bit
            || r_reg.ext_lock;
        power_save_operation = !continuous_switching;
        // Discharge only after a first enable and when permitted
        discharge_on = r_reg.ctrl.discharge_enable_bit && r_reg.enabled_once
            && (!en_pin || !r_reg.ctrl.switching_enable_bit || tsd || lo_sup
            || hi_sup);
        // Open drain: drive low unless good; secondary pulls whenever it is not in run
        power_ok_pin_o = 1'b0;
        power_ok_pin_oe = r_reg.secondary ? (r_reg.st != BPS_RUN)
            : !pok_on;
        dcm_only = r_reg.secondary && !r_reg.ccm_ok;
        spread_offset = r_reg.tri_ofs;
        soft_start_req = r_reg.ss_req;
        reg_rdata = r_reg.rdata;
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_force_bit;
        reg_wr && hit(reg_addr, `BPS_ADDR_CTRL1) && reg_wdata[0]
            |=> continuous_switching;
    endproperty
    a_force_bit: assert property (p_force_bit)
        else $error("force bit did not force PWM");
    property p_spread_gate;
        spread_offset != 8'sh00 |-> $past(spread_on);
    endproperty
    a_spread_gate: assert property (p_spread_gate)
        else $error("spreading while disabled");
    property p_spread_range;
        (spread_offset <= AMP) && (spread_offset >= -AMP);
    endproperty
    a_spread_range: assert property (p_spread_range)
        else $error("spreading outside amplitude");
    property p_disch_once;
        discharge_on |-> r_reg.enabled_once && r_reg.ctrl[2];
    endproperty
    a_disch_once: assert property (p_disch_once)
        else $error("discharge without first enable or permission");
    property p_limit_hold;
        r_reg.limiting && !below_s |=> !hs_on_allow;
    endproperty
    a_limit_hold: assert property (p_limit_hold)
        else $error("high side re-enabled during limit");
    property p_pause_len;
        $rose(r_reg.st == BPS_PAUSE) |-> (r_reg.st != BPS_SOFTSTART)[*8];
    endproperty
    a_pause_len: assert property (p_pause_len)
        else $error("hiccup pause ended early");
    property p_hic_flag;
        hic_hit |=> r_reg.hiccup_flag && !pok_on;
    endproperty
    a_hic_flag: assert property (p_hic_flag)
        else $error("hiccup did not flag or drop power-ok");
    property p_hic_keep;
        st_read && overload && r_reg.hiccup_flag |=> r_reg.hiccup_flag;
    endproperty
    a_hic_keep: assert property (p_hic_keep)
        else $error("hiccup flag cleared under overload");
    property p_limit_set;
        $rose(r_reg.current_limit_flag) |-> $past(r_reg.consec) >= 6'h03;
    endproperty
    a_limit_set: assert property (p_limit_set)
        else $error("limit flag set too early");
    property p_pok_low;
        (r_reg.st != BPS_RUN) || tsd || !en_pin |-> !pok_on;
    endproperty
    a_pok_low: assert property (p_pok_low)
        else $error("power-ok high while it must be low");
endmodule : bps_supervisor
`default_nettype wire

//--- design/bps_params.svh
// Offsets, field positions, reset values and timing of the supervisor
`ifndef BPS_PARAMS_SVH
`define BPS_PARAMS_SVH
// Clock period of the supervisor clock
`define BPS_CLK_NS 8
// Hiccup pause and power-ok deglitch times
`define BPS_HICCUP_PAUSE_NS 128000
`define BPS_POK_DEGLITCH_NS 40000
// Cycle counts of the overload responses
`define BPS_HICCUP_CYCLES 32
`define BPS_LIMIT_CYCLES 4
// Spreading amplitude in percent of the nominal period
`define BPS_SPREAD_PCT 10
// Register indices
`define BPS_ADDR_CTRL1 4'h0
`define BPS_ADDR_CTRL3 4'h1
`define BPS_ADDR_STATUS 4'h2
// Field positions of control_reg_one
`define BPS_C1_FORCE 0
`define BPS_C1_SPREAD 1
`define BPS_C1_DISCH 2
`define BPS_C1_SWITCH 3
`define BPS_C1_RETRY 4
// Field positions of control_reg_three
`define BPS_C3_BLANK 0
// Reset values: discharge and switching enabled
`define BPS_CTRL1_RST 5'h0c
`define BPS_CTRL3_RST 1'h0
`endif

//--- design/bps_pkg.sv
// Types shared by the buck protection supervisor
`default_nettype none
package bps_pkg;
    // Converter sequencing states, one-hot
    typedef enum logic [3:0] {
        BPS_OFF = 4'h1,
        BPS_SOFTSTART = 4'h2,
        BPS_RUN = 4'h4,
        BPS_PAUSE = 4'h8
    } bps_state_t;
    // Supply and thermal fault levels
    typedef struct packed {
        logic thermal_shdn;
        logic supply_low_lockout;
        logic supply_high_lockout;
    } bps_faults_t;
    // Control bits of control_reg_one, bit 0 last
    typedef struct packed {
        logic retry_mode_enable_bit;
        logic switching_enable_bit;
        logic discharge_enable_bit;
        logic spread_enable_bit;
        logic force_pwm_bit;
    } bps_ctrl_t;
    // Whole state of the core
    typedef struct packed {
        bps_state_t st;
        bps_ctrl_t ctrl;
        logic blank;
        logic hiccup_flag;
        logic current_limit_flag;
        logic enabled_once;
        logic limiting;
        logic cyc_limited;
        logic [5:0] consec;
        logic [9:0] osc;
        logic signed [7:0] tri_ofs;
        logic tri_up;
        logic [9:0] gap;
        logic ext_lock;
        logic mode_d;
        logic [7:0] rdata;
        logic secondary;
        logic strap_done;
        logic ccm_ok;
        logic pok_in_d;
        logic ss_req;
    } bps_core_t;
    // Timer state
    typedef struct packed {
        logic [15:0] cnt;
        logic done;
    } bps_timer_t;
endpackage : bps_pkg
`default_nettype wire

//--- design/bps_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module bps_sync #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage feeds only the second stage
    logic [2*W-1:0] s_reg, s_next;

    // Shift the levels one stage
    always_comb begin
        s_next = {s_reg[W-1:0], d};
    end

    // Register both stages
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Second stage is the clean copy
    assign q = s_reg[2*W-1:W];
endmodule : bps_sync
`default_nettype wire

//--- design/bps_timer.sv
// Hold timer: done rises after run has stood for limit cycles
`timescale 1ns/1ps
`default_nettype none
module bps_timer
    import bps_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic run,
    input wire logic [15:0] limit,
    output logic done
);
    bps_timer_t t_reg, t_next;

    // Count while run holds, restart on its loss
    always_comb begin
        t_next = t_reg;
        if (!run) begin
            t_next = '0;
        end else if (!t_reg.done) begin
            t_next.cnt = t_reg.cnt + 16'h0001;
            t_next.done = (t_next.cnt >= limit);
        end
    end

    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign done = t_reg.done;
endmodule : bps_timer
`default_nettype wire

//--- sim/bps_conv_model.sv
// Behavioural power stage seen by the supervisor: current and soft start
`timescale 1ns/1ps
`default_nettype none
module bps_conv_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic overload,
    input wire logic cycle_tick,
    input wire logic ls_force_on,
    input wire logic soft_start_req,
    input wire logic switching_run,
    output logic hs_limit_trip,
    output logic ls_below_limit,
    output logic soft_start_done
);
    // Ramp and decay counters
    logic [5:0] ss_cnt;
    logic [2:0] fall_cnt;
    // Inductor current and soft start ramp
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hs_limit_trip <= 1'b0;
            ls_below_limit <= 1'b1;
            fall_cnt <= '0;
            ss_cnt <= '0;
            soft_start_done <= 1'b0;
        end else begin
            // Overload trips at each new switching cycle
            if (cycle_tick && overload && switching_run) begin
                hs_limit_trip <= 1'b1;
                ls_below_limit <= 1'b0;
                fall_cnt <= 3'h5;
            end else if (ls_force_on) begin
                // Low side on: current decays after a few clocks
                hs_limit_trip <= 1'b0;
                if (fall_cnt != 0) fall_cnt <= fall_cnt - 3'h1;
                else ls_below_limit <= 1'b1;
            end
            // Ramp lasts 30 clocks, lost whenever switching stops
            if (soft_start_req || !switching_run) begin
                ss_cnt <= '0;
                soft_start_done <= 1'b0;
            end else if (ss_cnt == 6'd30) soft_start_done <= 1'b1;
            else ss_cnt <= ss_cnt + 6'd1;
        end
    end
endmodule : bps_conv_model
`default_nettype wire

//--- sim/test_buck_protection_supervisor.sv
// Self-checking bench of the buck protection supervisor
`timescale 1ns/1ps
`default_nettype none
`include "bps_params.svh"
module test_buck_protection_supervisor;
    import bps_pkg::*;
    logic clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, en_pin = 0;
    logic [3:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata, d;
    logic mode_clk_pin = 0, window_fault = 1, voltage_ramping = 0;
    logic overload = 0, hs_limit_trip, ls_below_limit, soft_start_done;
    bps_faults_t faults = '0;
    logic pok_o, pok_oe, pok_wire, run, hs_ok, ls_on, tick, cont, psave;
    logic disch, ss_req, dcm, strap = 0;
    logic signed [7:0] spread;
    int n_errors = 0, total_checks = 0, i, mx;
    // Clock of 8 ns
    always #4 clock = ~clock;
    // Shared power-ok wire with pull-up
    assign pok_wire = pok_oe ? pok_o : 1'b1;
    bps_supervisor #(.HICCUP_CYC(40), .DEGLITCH_CYC(20)) DUT (
        .clock(clock), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .en_pin(en_pin), .mode_clk_pin(mode_clk_pin),
        .faults(faults), .hs_limit_trip(hs_limit_trip),
        .ls_below_limit(ls_below_limit), .window_fault(window_fault),
        .voltage_ramping(voltage_ramping), .soft_start_done(soft_start_done),
        .secondary_strap(strap), .power_ok_pin_i(pok_wire),
        .power_ok_pin_o(pok_o), .power_ok_pin_oe(pok_oe),
        .switching_run(run), .hs_on_allow(hs_ok), .ls_force_on(ls_on),
        .cycle_tick(tick), .continuous_switching(cont),
        .power_save_operation(psave), .spread_offset(spread),
        .discharge_on(disch), .soft_start_req(ss_req), .dcm_only(dcm));
    bps_conv_model conv (.clock(clock), .rstn(rstn), .overload(overload),
        .cycle_tick(tick), .ls_force_on(ls_on), .soft_start_req(ss_req),
        .switching_run(run), .hs_limit_trip(hs_limit_trip),
        .ls_below_limit(ls_below_limit), .soft_start_done(soft_start_done));
    // Compare and count
    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // One-cycle register write
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // Read; data stands only in the following cycle
    task rd(input logic [3:0] a);
        @(posedge clock);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // Verdict
    task conclude;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // Reset values, unmapped index, discharge before first enable
    task t_reset;
        chk(pok_oe, 1, "pok in reset");
        chk(pok_o, 0, "open drain drives low");
        rd(`BPS_ADDR_CTRL1); chk(d, 8'h0c, "ctrl1 reset");
        rd(`BPS_ADDR_CTRL3); chk(d, 8'h00, "ctrl3 reset");
        rd(4'hf); chk(d, 8'h00, "unmapped read");
        cyc(3); chk(disch, 0, "discharge before enable");
    endtask : t_reset
    // Mode pin OR force bit
    task t_mode;
        chk(psave, 1, "pin low power save");
        mode_clk_pin <= 1; cyc(4); chk(cont, 1, "pin high pwm");
        mode_clk_pin <= 0; wr(`BPS_ADDR_CTRL1, 8'h0d); cyc(4);
        chk(cont, 1, "force bit pwm");
        wr(`BPS_ADDR_CTRL1, 8'h0c); cyc(4); chk(cont, 0, "both low");
    endtask : t_mode
    // Start-up with deglitched power-ok and ramp blanking
    task t_start;
        en_pin <= 1;
        for (i = 0; i < 20 && ss_req !== 1; i++) cyc(1);
        chk(ss_req, 1, "soft start requested");
        window_fault <= 0; cyc(10); chk(pok_oe, 1, "pok low in ramp");
        for (i = 0; i < 60 && soft_start_done !== 1; i++) cyc(1);
        cyc(12); chk(pok_oe, 1, "deglitch holds");
        cyc(20); chk(pok_oe, 0, "pok released");
        window_fault <= 1; cyc(4); chk(pok_oe, 1, "window fault");
        window_fault <= 0; cyc(30); wr(`BPS_ADDR_CTRL3, 8'h01);
        voltage_ramping <= 1; window_fault <= 1; cyc(8);
        chk(pok_oe, 0, "blanked in ramp");
        voltage_ramping <= 0; window_fault <= 0; cyc(4);
    endtask : t_start
    // Plain limiting sets the limit flag, cleared only after overload
    task t_limit;
        overload <= 1;
        for (i = 0; i < 60 && ls_on !== 1; i++) cyc(1);
        chk(ls_on, 1, "low side forced");
        chk(hs_ok, 0, "high side blocked");
        cyc(240);
        rd(`BPS_ADDR_STATUS); chk(d[1], 1, "limit flag");
        rd(`BPS_ADDR_STATUS); chk(d[1], 1, "kept in overload");
        overload <= 0; cyc(150); rd(`BPS_ADDR_STATUS); rd(`BPS_ADDR_STATUS);
        chk(d[1], 0, "cleared after overload");
        chk(d[0], 0, "no hiccup in limit mode");
    endtask : t_limit
    // Hiccup pause, flag and restart
    task t_hiccup;
        wr(`BPS_ADDR_CTRL1, 8'h1c); overload <= 1;
        for (i = 0; i < 2000 && run !== 0; i++) cyc(1);
        chk(run, 0, "hiccup pause");
        chk(i > 1400, 1, "after 32 cycles");
        chk(pok_oe, 1, "pok low in hiccup");
        rd(`BPS_ADDR_STATUS); chk(d[0], 1, "hiccup flag");
        for (i = 0; i < 60 && ss_req !== 1; i++) cyc(1);
        chk(i > 30, 1, "pause length then restart");
        chk(ss_req, 1, "restart after pause");
        rd(`BPS_ADDR_STATUS); chk(d[0], 1, "kept in overload");
        overload <= 0; wr(`BPS_ADDR_CTRL1, 8'h0c); cyc(300);
        rd(`BPS_ADDR_STATUS); rd(`BPS_ADDR_STATUS);
        chk(d[0], 0, "hiccup cleared");
    endtask : t_hiccup
    // Supply lockouts, disable and discharge permission
    task t_lockout;
        faults.supply_high_lockout <= 1; cyc(5);
        chk(run, 0, "stop on high supply");
        chk(disch, 1, "discharge high supply");
        faults.supply_high_lockout <= 0;
        for (i = 0; i < 10 && ss_req !== 1; i++) cyc(1);
        chk(ss_req, 1, "fresh soft start");
        faults.supply_low_lockout <= 1; cyc(5);
        chk(run, 0, "stop on low supply");
        chk(pok_oe, 1, "pok low in lockout");
        faults.supply_low_lockout <= 0; faults.thermal_shdn <= 1; cyc(5);
        chk(disch, 1, "discharge thermal");
        faults.thermal_shdn <= 0; wr(`BPS_ADDR_CTRL1, 8'h04); cyc(3);
        chk(disch, 1, "discharge switching off");
        wr(`BPS_ADDR_CTRL1, 8'h0c); en_pin <= 0; cyc(4);
        chk(disch, 1, "discharge pin low");
        wr(`BPS_ADDR_CTRL1, 8'h08); cyc(3);
        chk(disch, 0, "discharge not permitted");
    endtask : t_lockout
    // Spreading range, disable, and external clock lock
    task t_spread;
        wr(`BPS_ADDR_CTRL1, 8'h0a); mx = 0;
        repeat (600) begin
            cyc(1);
            if (spread > mx) mx = spread;
            if (-spread > mx) mx = -spread;
        end
        chk(mx, 5, "spread amplitude");
        for (i = 0; i < 10; i++) begin
            mode_clk_pin <= 1; cyc(20); mode_clk_pin <= 0; cyc(20);
        end
        rd(`BPS_ADDR_STATUS); chk(d[4], 1, "clock lock");
        chk(cont, 1, "lock forces pwm");
        chk(spread, 0, "no spread on ext clock");
        cyc(150); wr(`BPS_ADDR_CTRL1, 8'h08); cyc(5);
        chk(spread, 0, "spread disabled");
    endtask : t_spread
    // Secondary role: holds power-ok low until run, leaves DCM on its edge
    task t_second;
        strap <= 1; rstn <= 0; cyc(2); rstn <= 1; cyc(3);
        chk(dcm, 1, "secondary starts in DCM");
        chk(pok_oe, 1, "secondary pulls in start");
        en_pin <= 1; cyc(60);
        chk(pok_oe, 0, "secondary releases");
        chk(dcm, 0, "CCM after power-ok edge");
    endtask : t_second
    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        #400_000;
        n_errors++;
        conclude();
    end
    // Main sequence
    initial begin
        cyc(4);
        rstn <= 1;
        t_reset(); t_mode(); t_start(); t_limit(); t_hiccup();
        t_lockout(); t_spread(); t_second();
        conclude();
    end
endmodule : test_buck_protection_supervisor
`default_nettype wire
